// file: soc_top.sv
// safety output control: state machine, register slave, interrupt
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "soc_consts.svh"
module soc_top #(
  parameter int unsigned DISC_CYCLES = `SOC_DISC_TIME_MS * `SOC_CLK_KHZ,
  parameter int unsigned DIAG_CYCLES = `SOC_DIAG_PERIOD_MS * `SOC_CLK_KHZ
) (
  input wire logic mclk, // 25 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic beamClear, // all beams received
  input wire logic hwFault, // internal self-test failure
  input wire logic fbA, // output a readback
  input wire logic fbB, // output b readback
  input wire logic polSenseHigh, // polarity strap at +V
  input wire logic polSenseLow, // polarity strap at 0V
  input wire logic ilkSenseHigh, // interlock strap at +V
  input wire logic ilkSenseLow, // interlock strap at 0V
  input wire logic testSenseHigh, // test/reset line at +V
  input wire logic testSenseLow, // test/reset line at 0V
  input wire logic in1High, // safety input 1 at +V
  input wire logic in1Low, // safety input 1 at 0V
  input wire logic in2High, // safety input 2 at +V
  input wire logic in2Low, // safety input 2 at 0V
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire soc_pkg::soc_addr_t s_axi_awaddr, // write address
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input wire soc_pkg::soc_word_t s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input wire soc_pkg::soc_addr_t s_axi_araddr, // read address
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output soc_pkg::soc_word_t s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic safetyOutA, // safety_out_a
  output logic safetyOutB, // safety_out_b
  output logic rxRedInd, // receiver output indicator red
  output logic txRedInd, // emitter operation indicator red
  output logic lockoutInd, // lockout state
  output logic irq // level interrupt
);
  import soc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  logic strapTaken_q, highSide_q, manual_q, strapBad_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strapTaken_q <= 1'b0;
      highSide_q <= 1'b0;
      manual_q <= 1'b0;
      strapBad_q <= 1'b0;
    end else if (ce && !strapTaken_q) begin
      strapTaken_q <= 1'b1;
      highSide_q <= polSenseHigh;
      strapBad_q <= polSenseHigh == polSenseLow;
      manual_q <= ilkSenseHigh || ilkSenseLow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers written by software
  logic sensorMode_q;
  logic [1:0] sensorCnt_q;
  logic [`SOC_EVT_W-1:0] evt_q, mask_q, evtSet, evtClr;
  logic wrDo;
  soc_addr_t wrAddr_q;
  soc_word_t wrData_q;
  logic [3:0] wrStrb_q;
  assign wrDo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // control and mask registers; illegal sensor counts are ignored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sensorMode_q <= 1'(`SOC_CTRL_RESET >> `SOC_CTRL_SENSOR_BIT);
      sensorCnt_q <= 2'(`SOC_CTRL_RESET >> `SOC_CTRL_CNT_LSB);
      mask_q <= `SOC_MASK_RESET;
    end else if (ce && wrDo && wrStrb_q[0]) begin
      if (wrAddr_q == `SOC_REG_CTRL) begin
        sensorMode_q <= wrData_q[`SOC_CTRL_SENSOR_BIT];
        if (wrData_q[`SOC_CTRL_CNT_MSB:`SOC_CTRL_CNT_LSB] != 2'h0 &&
            wrData_q[`SOC_CTRL_CNT_MSB:`SOC_CTRL_CNT_LSB] <= `SOC_SENSOR_MAX) begin
          sensorCnt_q <= wrData_q[`SOC_CTRL_CNT_MSB:`SOC_CTRL_CNT_LSB];
        end
      end else if (wrAddr_q == `SOC_REG_MASK) begin
        mask_q <= wrData_q[`SOC_EVT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input qualification
  logic ch1Act, ch2Act, ch1Opp, ch2Opp, unusedContact, inputOk, mismatch;
  logic testAtRail, testActive, testPrev_q, resetEvt, onCond;
  soc_chk_if chk ();
  assign ch1Act = highSide_q ? in1High : in1Low;
  assign ch2Act = highSide_q ? in2High : in2Low;
  assign ch1Opp = highSide_q ? in1Low : in1High;
  assign ch2Opp = highSide_q ? in2Low : in2High;
  // contact pair left unused: ch1 at +V, ch2 at 0V
  assign unusedContact = in1High && !in1Low && in2Low && !in2High;
  assign inputOk = (ch1Act && ch2Act) || (!sensorMode_q && unusedContact);
  assign mismatch = sensorMode_q && (ch1Opp || ch2Opp);
  assign chk.chA = ch1Act || (!sensorMode_q && unusedContact);
  assign chk.chB = ch2Act || (!sensorMode_q && unusedContact);
  // test line sense flips with the reset mode
  assign testAtRail = highSide_q ? testSenseHigh : testSenseLow;
  assign testActive = manual_q ? testAtRail : !testAtRail;
  assign resetEvt = manual_q && testPrev_q && !testActive;
  assign onCond = beamClear && !testActive && inputOk && !mismatch &&
                  !chk.discFault;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      testPrev_q <= 1'b0;
    end else if (ce) begin
      testPrev_q <= testActive;
    end
  end

  soc_pair_mon #(.LIMIT(DISC_CYCLES)) uPair (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .chk(chk)
  );

  ////////////////////////////////////////////////////////////////////////
  // self-diagnosis
  logic initDone_q, outPrev_q;
  assign chk.hwFault = hwFault;
  // readback checked only once the command has settled
  assign chk.fbMismatch = (outPrev_q == safetyOutA) &&
                          ((fbA != safetyOutA) || (fbB != safetyOutB));
  soc_diag #(.PERIOD(DIAG_CYCLES)) uDiag (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .chk(chk)
  );
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      initDone_q <= 1'b0;
      outPrev_q <= 1'b0;
    end else if (ce) begin
      outPrev_q <= safetyOutA;
      if (chk.diagDone) begin
        initDone_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output state machine
  soc_state_t state_q, state_d;
  logic lockReq;
  assign lockReq = chk.diagFault || (strapTaken_q && strapBad_q);
  always_comb begin
    state_d = state_q;
    if (lockReq || state_q == SOC_LOCK) begin
      state_d = SOC_LOCK;
    end else begin
      case (state_q)
        SOC_BOOT: begin
          if (initDone_q && strapTaken_q) begin
            state_d = manual_q ? SOC_ILK : SOC_OFF;
          end
        end
        SOC_OFF: begin
          if (manual_q && !beamClear) begin
            state_d = SOC_ILK;
          end else if (onCond) begin
            state_d = SOC_ON;
          end
        end
        SOC_ON: begin
          if (!onCond) begin
            state_d = (manual_q && !beamClear) ? SOC_ILK : SOC_OFF;
          end
        end
        SOC_ILK: begin
          if (resetEvt && onCond) begin
            state_d = SOC_ON;
          end
        end
        default: begin
          state_d = SOC_LOCK;
        end
      endcase
    end
  end

  // state and pin outputs; both outputs share one decision
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SOC_BOOT;
      safetyOutA <= 1'b0;
      safetyOutB <= 1'b0;
      rxRedInd <= 1'b0;
      txRedInd <= 1'b0;
      lockoutInd <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      safetyOutA <= state_d == SOC_ON;
      safetyOutB <= state_d == SOC_ON;
      rxRedInd <= !beamClear;
      txRedInd <= !beamClear;
      lockoutInd <= state_d == SOC_LOCK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear, set wins
  logic discPrev_q, mismPrev_q;
  assign evtSet = {mismatch && !mismPrev_q, chk.discFault && !discPrev_q,
                   safetyOutA && state_d != SOC_ON,
                   state_d == SOC_LOCK && state_q != SOC_LOCK};
  assign evtClr = (wrDo && wrStrb_q[0] && wrAddr_q == `SOC_REG_EVENT) ?
                  wrData_q[`SOC_EVT_W-1:0] : 4'h0;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= 4'h0;
      discPrev_q <= 1'b0;
      mismPrev_q <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      evt_q <= (evt_q & ~evtClr) | evtSet;
      discPrev_q <= chk.discFault;
      mismPrev_q <= mismatch;
      irq <= |(((evt_q & ~evtClr) | evtSet) & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write channels: address and data taken in either order
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SOC_RESP_OKAY;
      wrAddr_q <= 8'h00;
      wrData_q <= 32'h0000_0000;
      wrStrb_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wrAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wrData_q <= s_axi_wdata;
        wrStrb_q <= s_axi_wstrb;
      end
      if (wrDo) begin
        s_axi_bvalid <= 1'b1;
        if (wrAddr_q == `SOC_REG_CTRL || wrAddr_q == `SOC_REG_MASK ||
            wrAddr_q == `SOC_REG_EVENT || wrAddr_q == `SOC_REG_STATUS) begin
          s_axi_bresp <= `SOC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `SOC_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel with one cycle of latency
  soc_word_t status;
  always_comb begin
    status = 32'h0000_0000;
    status[`SOC_ST_ON] = safetyOutA;
    status[`SOC_ST_LOCK] = state_q == SOC_LOCK;
    status[`SOC_ST_ILK] = state_q == SOC_ILK;
    status[`SOC_ST_MANUAL] = manual_q;
    status[`SOC_ST_POLHI] = highSide_q;
    status[`SOC_ST_TEST] = testActive;
    status[`SOC_ST_INOK] = inputOk;
    status[`SOC_ST_MISM] = mismatch;
    status[`SOC_ST_DISC] = chk.discFault;
    status[`SOC_ST_BEAM] = beamClear;
    status[`SOC_ST_INIT] = initDone_q;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SOC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SOC_RESP_OKAY;
        if (s_axi_araddr == `SOC_REG_CTRL) begin
          s_axi_rdata <= {29'h0, sensorCnt_q, sensorMode_q};
        end else if (s_axi_araddr == `SOC_REG_STATUS) begin
          s_axi_rdata <= status;
        end else if (s_axi_araddr == `SOC_REG_EVENT) begin
          s_axi_rdata <= {28'h0, evt_q};
        end else if (s_axi_araddr == `SOC_REG_MASK) begin
          s_axi_rdata <= {28'h0, mask_q};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SOC_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_boot_diag;
    @(posedge mclk) disable iff (!rst_n || !ce)
    (state_q == SOC_BOOT && !lockReq) |-> ##[1:4] state_q != SOC_BOOT;
  endproperty
  a_boot_diag: assert property (p_boot_diag) else $error("power-up diagnosis stalled");
  property p_diag_lock;
    @(posedge mclk) disable iff (!rst_n || !ce)
    chk.diagFault |=> (state_q == SOC_LOCK && !safetyOutA && !safetyOutB);
  endproperty
  a_diag_lock: assert property (p_diag_lock) else $error("fault did not lock out");
  property p_lock_stays;
    @(posedge mclk) disable iff (!rst_n)
    state_q == SOC_LOCK |=> (state_q == SOC_LOCK && !safetyOutA);
  endproperty
  a_lock_stays: assert property (p_lock_stays) else $error("lockout left");
  property p_same_out;
    @(posedge mclk) disable iff (!rst_n)
    safetyOutA == safetyOutB;
  endproperty
  a_same_out: assert property (p_same_out) else $error("outputs differ");
  property p_ilk_hold;
    @(posedge mclk) disable iff (!rst_n || !ce)
    (state_q == SOC_ILK && !resetEvt) |=> !safetyOutA;
  endproperty
  a_ilk_hold: assert property (p_ilk_hold) else $error("interlock released early");
  property p_input_off;
    @(posedge mclk) disable iff (!rst_n || !ce)
    (!inputOk || mismatch) |=> !safetyOutA;
  endproperty
  a_input_off: assert property (p_input_off) else $error("input off yet on");
  property p_blocked;
    @(posedge mclk) disable iff (!rst_n || !ce)
    !beamClear |=> (!safetyOutA && rxRedInd && txRedInd);
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked area not off");
  property p_auto_on;
    @(posedge mclk) disable iff (!rst_n || !ce)
    (state_q == SOC_OFF && !manual_q && onCond && !lockReq) |=> safetyOutA;
  endproperty
  a_auto_on: assert property (p_auto_on) else $error("auto reset did not turn on");
  property p_test_off;
    @(posedge mclk) disable iff (!rst_n || !ce)
    testActive |=> !safetyOutA;
  endproperty
  a_test_off: assert property (p_test_off) else $error("test did not force off");
  c_on: cover property (@(posedge mclk) disable iff (!rst_n) $rose(safetyOutA));
  c_lock: cover property (@(posedge mclk) disable iff (!rst_n) $rose(lockoutInd));
  c_ilk_reset: cover property (@(posedge mclk) disable iff (!rst_n)
    state_q == SOC_ILK ##1 state_q == SOC_ON);
endmodule : soc_top
`default_nettype wire

// file: soc_consts.svh
// constants for the safety output control block
`ifndef SOC_CONSTS_SVH
`define SOC_CONSTS_SVH
// register byte offsets
`define SOC_REG_CTRL 8'h00
`define SOC_REG_STATUS 8'h04
`define SOC_REG_EVENT 8'h08
`define SOC_REG_MASK 8'h0C
// control fields and reset value
`define SOC_CTRL_SENSOR_BIT 0
`define SOC_CTRL_CNT_LSB 1
`define SOC_CTRL_CNT_MSB 2
`define SOC_CTRL_RESET 32'h0000_0002
`define SOC_SENSOR_MAX 2'h2
// event bits
`define SOC_EVT_LOCK 0
`define SOC_EVT_OFF 1
`define SOC_EVT_DISC 2
`define SOC_EVT_MISM 3
`define SOC_EVT_W 4
`define SOC_MASK_RESET 4'h0
// status bits
`define SOC_ST_ON 0
`define SOC_ST_LOCK 1
`define SOC_ST_ILK 2
`define SOC_ST_MANUAL 3
`define SOC_ST_POLHI 4
`define SOC_ST_TEST 5
`define SOC_ST_INOK 6
`define SOC_ST_MISM 7
`define SOC_ST_DISC 8
`define SOC_ST_BEAM 9
`define SOC_ST_INIT 10
// bus responses
`define SOC_RESP_OKAY 2'h0
`define SOC_RESP_SLVERR 2'h2
// timing: clock rate, channel skew limit, diagnosis period
`define SOC_CLK_KHZ 25000
`define SOC_DISC_TIME_MS 1000
`define SOC_DIAG_PERIOD_MS 10
`endif

// file: soc_pkg.sv
// types shared by the safety output control modules
package soc_pkg;
  typedef enum logic [2:0] {SOC_BOOT, SOC_OFF, SOC_ON, SOC_ILK, SOC_LOCK} soc_state_t;
  typedef logic [31:0] soc_word_t;
  typedef logic [7:0] soc_addr_t;
endpackage : soc_pkg

// file: soc_chk_if.sv
// carrier between the core and its checking helpers
`timescale 1ns/10ps
`default_nettype none
interface soc_chk_if;
  logic chA;
  logic chB;
  logic discFault;
  logic hwFault;
  logic fbMismatch;
  logic diagFault;
  logic diagDone;
  modport pairMp (input chA, input chB, output discFault);
  modport diagMp (input hwFault, input fbMismatch, output diagFault, output diagDone);
  modport coreMp (output chA, output chB, input discFault, output hwFault,
    output fbMismatch, input diagFault, input diagDone);
endinterface : soc_chk_if
`default_nettype wire

// file: soc_pair_mon.sv
// two-channel skew monitor for the safety input
`timescale 1ns/10ps
`default_nettype none
module soc_pair_mon #(
  parameter int unsigned LIMIT = 25000000
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable
  soc_chk_if.pairMp chk // channel levels in, fault out
);
  logic [31:0] cnt_q;
  logic disc_q;
  assign chk.discFault = disc_q;
  // count while channels differ; fault holds until they agree again
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0000_0000;
      disc_q <= 1'b0;
    end else if (ce) begin
      if (chk.chA == chk.chB) begin
        cnt_q <= 32'h0000_0000;
        disc_q <= 1'b0;
      end else if (cnt_q >= 32'(LIMIT - 1)) begin
        disc_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end
endmodule : soc_pair_mon
`default_nettype wire

// file: soc_diag.sv
// self-diagnosis scheduler: at power-up, then every period
`timescale 1ns/10ps
`default_nettype none
module soc_diag #(
  parameter int unsigned PERIOD = 250000
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable
  soc_chk_if.diagMp chk // fault sources in, verdict out
);
  logic [31:0] cnt_q;
  logic done_q;
  logic fault_q;
  assign chk.diagDone = done_q;
  assign chk.diagFault = fault_q;
  // counter at zero after reset runs the first check at once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0000_0000;
      done_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (ce) begin
      done_q <= (cnt_q == 32'h0000_0000);
      fault_q <= (cnt_q == 32'h0000_0000) && (chk.hwFault || chk.fbMismatch);
      if (cnt_q == 32'h0000_0000) begin
        cnt_q <= 32'(PERIOD - 1);
      end else begin
        cnt_q <= cnt_q - 32'h0000_0001;
      end
    end
  end
endmodule : soc_diag
`default_nettype wire

// file: soc_field_model.sv
// machine-side partner: strap wiring, safety input lines, relay readback
`timescale 1ns/10ps
`default_nettype none
module soc_field_model (
  input wire logic mclk, // system clock
  input wire logic [9:0] lineCode, // five lines, 2 bits each: 0 open, 1 at +V, 2 at 0V
  input wire logic outA, // safety_out_a
  input wire logic outB, // safety_out_b
  output logic [9:0] railSense, // per line {at +V, at 0V}
  output logic fbA, // relay a readback
  output logic fbB // relay b readback
);
  ////////////////////////////////////////////////////////////////////////
  // each line reports its rail; an open line shows neither level
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      railSense[2*i+1] = (lineCode[2*i+:2] == 2'h1);
      railSense[2*i] = (lineCode[2*i+:2] == 2'h2);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // relay contacts follow the outputs one clock later
  always_ff @(posedge mclk) begin
    fbA <= outA;
    fbB <= outB;
  end
endmodule : soc_field_model
`default_nettype wire

// file: safety_output_control_tb.sv
// testbench for the safety output control block
`timescale 1ns/10ps
`default_nettype none
`include "soc_consts.svh"
module safety_output_control_tb;
  import soc_pkg::*;
  localparam logic [1:0] OPN = 2'h0, HI = 2'h1, LO = 2'h2;
  logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, beamClear = 1'b1, hwFault = 1'b0;
  logic [1:0] polL = HI, ilkL = OPN, testL = HI, in1L = HI, in2L = HI;
  logic [9:0] rs;
  logic fbA, fbB, awr, wr, bv, arr, rv, oA, oB, rxR, txR, lockO, irq;
  logic awv = 1'b0, wv = 1'b0, bra = 1'b0, arv = 1'b0, rra = 1'b0;
  logic [1:0] bresp, rresp, resp;
  soc_addr_t awa = 8'h0, ara = 8'h0;
  soc_word_t wd = 32'h0, rd, val;
  int nErrors = 0, comparisons = 0, cyc = 0;
  always #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  // partner and design
  soc_field_model fm (.mclk(mclk), .lineCode({polL, ilkL, testL, in1L, in2L}), .outA(oA),
    .outB(oB), .railSense(rs), .fbA(fbA), .fbB(fbB));
  soc_top #(.DISC_CYCLES(20), .DIAG_CYCLES(16)) dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .beamClear(beamClear), .hwFault(hwFault), .fbA(fbA), .fbB(fbB),
    .polSenseHigh(rs[9]), .polSenseLow(rs[8]), .ilkSenseHigh(rs[7]), .ilkSenseLow(rs[6]),
    .testSenseHigh(rs[5]), .testSenseLow(rs[4]), .in1High(rs[3]), .in1Low(rs[2]),
    .in2High(rs[1]), .in2Low(rs[0]), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bra), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rra), .s_axi_rdata(rd), .s_axi_rresp(rresp), .safetyOutA(oA),
    .safetyOutB(oB), .rxRedInd(rxR), .txRedInd(txR), .lockoutInd(lockO), .irq(irq));
  ////////////////////////////////////////////////////////////////////////
  // compare, bus access, reset and verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axiWrite(input soc_addr_t a, input soc_word_t d);
    @(posedge mclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bra <= 1'b1;
    do begin
      @(posedge mclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!(bv && bra));
    resp = bresp;
    bra <= 1'b0;
  endtask : axiWrite
  task automatic axiRead(input soc_addr_t a);
    @(posedge mclk);
    arv <= 1'b1;
    ara <= a;
    rra <= 1'b1;
    do begin
      @(posedge mclk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rra));
    resp = rresp;
    val = rd;
    rra <= 1'b0;
  endtask : axiRead
  task automatic expOut(input logic e);
    repeat (6) @(posedge mclk);
    chk("safety outputs", {30'h0, oA, oB}, {30'h0, e, e});
  endtask : expOut
  task automatic doReset;
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : doReset
  task automatic finishTest;
    $display("comparisons %0d mismatches %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finishTest
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nErrors++;
      finishTest();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    doReset();
    axiRead(`SOC_REG_CTRL);
    chk("ctrl reset", val, `SOC_CTRL_RESET);
    axiRead(8'h40);
    chk("unmapped resp", {30'h0, resp}, {30'h0, `SOC_RESP_SLVERR});
    axiWrite(8'h40, 32'h1);
    chk("unmapped write resp", {30'h0, resp}, {30'h0, `SOC_RESP_SLVERR});
    expOut(1'b1);
    // clock enable low freezes outputs and indicators
    ce <= 1'b0;
    beamClear <= 1'b0;
    expOut(1'b1);
    chk("frozen red", {30'h0, rxR, txR}, 32'h0);
    ce <= 1'b1;
    beamClear <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("red indicators", {30'h0, rxR, txR}, 32'h3);
    expOut(1'b0);
    beamClear <= 1'b1;
    expOut(1'b1);
    testL <= OPN;
    expOut(1'b0);
    testL <= HI;
    in2L <= LO;
    expOut(1'b1);
    in2L <= HI;
    in1L <= OPN;
    expOut(1'b0);
    repeat (30) @(posedge mclk);
    axiRead(`SOC_REG_STATUS);
    chk("skew fault", {31'h0, val[`SOC_ST_DISC]}, 32'h1);
    in1L <= HI;
    expOut(1'b1);
    axiRead(`SOC_REG_EVENT);
    chk("event bits", val, 32'h0000_0006);
    axiWrite(`SOC_REG_MASK, 32'h2);
    chk("write resp", {30'h0, resp}, {30'h0, `SOC_RESP_OKAY});
    axiRead(`SOC_REG_MASK);
    chk("mask readback", val, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    axiWrite(`SOC_REG_EVENT, 32'hF);
    repeat (2) @(posedge mclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("auto mode test done");
    axiWrite(`SOC_REG_CTRL, 32'h3);
    axiWrite(`SOC_REG_CTRL, 32'h7);
    axiRead(`SOC_REG_CTRL);
    chk("sensor count", val, 32'h0000_0003);
    in2L <= LO;
    expOut(1'b0);
    in2L <= HI;
    expOut(1'b1);
    {polL, testL, in1L, in2L} <= {LO, LO, LO, LO};
    doReset();
    expOut(1'b1);
    {polL, ilkL, testL, in1L, in2L} <= {HI, LO, HI, HI, HI};
    doReset();
    expOut(1'b0);
    axiRead(`SOC_REG_STATUS);
    chk("manual status", val, 32'h0000_067C);
    testL <= OPN;
    expOut(1'b1);
    beamClear <= 1'b0;
    expOut(1'b0);
    beamClear <= 1'b1;
    expOut(1'b0);
    testL <= HI;
    expOut(1'b0);
    testL <= OPN;
    expOut(1'b1);
    $display("manual mode test done");
    hwFault <= 1'b1;
    repeat (40) @(posedge mclk);
    chk("lockout", {31'h0, lockO}, 32'h1);
    hwFault <= 1'b0;
    expOut(1'b0);
    axiRead(`SOC_REG_EVENT);
    chk("lockout event", val, 32'h0000_0003);
    polL <= OPN;
    doReset();
    repeat (10) @(posedge mclk);
    chk("strap lockout", {31'h0, lockO}, 32'h1);
    $display("lockout test done");
    finishTest();
  end
endmodule : safety_output_control_tb
`default_nettype wire
